// >>> design/ccr_pkg.sv
// Functional notes
// - Command register is write-only; host writes command codes to it.
// - Run code starts the card with current setting register values.
// - Halt code stops the running card immediately.
// - Registers without value constants are switches: one on, zero off.
// - Invalid command or setting records error code, register and value.
// - After an error, accesses return pending-error code until error readout.
// - Report-only codes such as wait timeout do not set the lock.
// - Only one open session at a time; second open returns error.
// - Board-type register is read-only and identifies the card variant.
// - Board-type low word holds model digits; upper word gives bus type.
// - Base-board version: hardware in 31..16, firmware in 15..0, read-only.
// - Front-end module version: hardware 31..16, firmware 15..0, read-only.
// - Extension module version: hardware 31..16, firmware 15..0, read-only.
// - Base PCB revision: major 15..8, minor 7..0, upper half zero.
// - Front-end PCB revision uses same format, upper half zero.
// - Extension PCB revision: major/minor bytes in 15..0, upper zero.
package ccr_pkg;
    localparam int REG_W = 32;
    localparam logic [REG_W-1:0] REG_CARD_COMMAND = 32'h0000_0064;
    localparam logic [REG_W-1:0] REG_SWITCH = 32'h0000_0065;
    localparam logic [REG_W-1:0] REG_ERROR_READOUT = 32'h0000_0066;
    localparam logic [REG_W-1:0] REG_OPEN = 32'h0000_0067;
    localparam logic [REG_W-1:0] REG_CLOSE = 32'h0000_0068;
    localparam logic [REG_W-1:0] REG_BOARD_TYPE_CODE = 32'h0000_07D0;
    localparam logic [REG_W-1:0] REG_BASE_BOARD_VERSION = 32'h0000_07DA;
    localparam logic [REG_W-1:0] REG_EXTENSION_MODULE_VERSION = 32'h0000_07DB;
    localparam logic [REG_W-1:0] REG_FRONT_END_MODULE_VERSION = 32'h0000_07DC;
    localparam logic [REG_W-1:0] REG_BASE_BOARD_PCB_REVISION = 32'h0000_07DE;
    localparam logic [REG_W-1:0] REG_FRONT_END_PCB_REVISION = 32'h0000_07DF;
    localparam logic [REG_W-1:0] REG_EXTENSION_PCB_REVISION = 32'h0000_07E1;
    localparam logic [REG_W-1:0] RUN_COMMAND = 32'h0000_0004;
    localparam logic [REG_W-1:0] HALT_COMMAND = 32'h0000_0040;
    localparam logic [REG_W-1:0] CMD_VALID_MASK = 32'h0000_004F;
    localparam logic [REG_W-1:0] ERR_NONE = 32'h0000_0000;
    localparam logic [REG_W-1:0] ERR_INVALID_REG = 32'h0000_0001;
    localparam logic [REG_W-1:0] ERR_INVALID_VALUE = 32'h0000_0002;
    localparam logic [REG_W-1:0] ERR_ALREADY_OPEN = 32'h0000_0003;
    localparam logic [REG_W-1:0] ERR_NOT_OPEN = 32'h0000_0004;
    localparam logic [REG_W-1:0] ERR_TIMEOUT = 32'h0000_0005;
    localparam logic [REG_W-1:0] PENDING_ERROR_CODE = 32'h0000_0006;
    localparam logic [REG_W-1:0] ERR_WRITE_ONLY = 32'h0000_0007;
    localparam int HALF_LO = 0;
    localparam int HALF_HI = 16;

    typedef struct packed {
        logic [REG_W-1:0] code;
        logic [REG_W-1:0] reg_num;
        logic [REG_W-1:0] value;
    } ccr_err_s;

    typedef enum logic {CCR_IDLE, CCR_RUNNING} ccr_run_e;
endpackage : ccr_pkg

// >>> design/ccr_card_regs.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_card_regs import ccr_pkg::*; #(
    parameter logic [15:0] BUS_TYPE = 16'h0001,       // Arbitrary
    parameter logic [15:0] MODEL_DIGITS = 16'h1234,   // Arbitrary
    parameter logic [15:0] BASE_HW_VER = 16'h0001,
    parameter logic [15:0] BASE_FW_VER = 16'h0001,
    parameter logic [15:0] FE_HW_VER = 16'h0001,
    parameter logic [15:0] FE_FW_VER = 16'h0001,
    parameter logic [15:0] EXT_HW_VER = 16'h0000,
    parameter logic [15:0] EXT_FW_VER = 16'h0000,
    parameter logic [7:0] BASE_PCB_MAJ = 8'h01,
    parameter logic [7:0] BASE_PCB_MIN = 8'h00,
    parameter logic [7:0] FE_PCB_MAJ = 8'h01,
    parameter logic [7:0] FE_PCB_MIN = 8'h00,
    parameter logic [7:0] EXT_PCB_MAJ = 8'h00,
    parameter logic [7:0] EXT_PCB_MIN = 8'h00
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register access
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic [REG_W-1:0] acc_reg,
    input wire logic [REG_W-1:0] acc_wdata,
    output logic acc_done,
    output logic [REG_W-1:0] acc_status,
    output logic [REG_W-1:0] acc_rdata,
    // Error readout
    output logic [REG_W-1:0] err_reg_out,
    output logic [REG_W-1:0] err_value_out,
    // Card control
    input wire logic wait_timeout,
    output logic card_running,
    output logic switch_on,
    output logic locked,
    output logic session_open
);
    ccr_err_s err_q;
    logic lock_q;
    logic open_q;
    logic switch_q;
    ccr_run_e run_q;
    logic done_q;
    logic [REG_W-1:0] status_q;
    logic [REG_W-1:0] rdata_q;
    logic [REG_W-1:0] err_reg_q;
    logic [REG_W-1:0] err_val_q;

    function automatic logic [REG_W-1:0] ver_word(input logic [15:0] hi, input logic [15:0] lo);
        ver_word = {hi, lo};
    endfunction : ver_word

    function automatic logic [REG_W-1:0] pcb_word(input logic [7:0] maj, input logic [7:0] mnr);
        pcb_word = {16'h0000, maj, mnr};
    endfunction : pcb_word

    // Combinational decode of one access
    logic rd_hit;
    logic [REG_W-1:0] rd_val;
    logic [REG_W-1:0] code_d;
    logic lockable_d;
    logic is_readout;
    logic ok_d;

    always_comb begin
        rd_hit = 1'b1;
        rd_val = '0;
        case (acc_reg)
            REG_BOARD_TYPE_CODE: rd_val = ver_word(BUS_TYPE, MODEL_DIGITS);
            REG_BASE_BOARD_VERSION: rd_val = ver_word(BASE_HW_VER, BASE_FW_VER);
            REG_FRONT_END_MODULE_VERSION: rd_val = ver_word(FE_HW_VER, FE_FW_VER);
            REG_EXTENSION_MODULE_VERSION: rd_val = ver_word(EXT_HW_VER, EXT_FW_VER);
            REG_BASE_BOARD_PCB_REVISION: rd_val = pcb_word(BASE_PCB_MAJ, BASE_PCB_MIN);
            REG_FRONT_END_PCB_REVISION: rd_val = pcb_word(FE_PCB_MAJ, FE_PCB_MIN);
            REG_EXTENSION_PCB_REVISION: rd_val = pcb_word(EXT_PCB_MAJ, EXT_PCB_MIN);
            REG_SWITCH: rd_val = {{(REG_W-1){1'b0}}, switch_q};
            default: rd_hit = 1'b0;
        endcase
    end

    assign is_readout = (acc_reg == REG_ERROR_READOUT) && !acc_write;

    always_comb begin
        code_d = ERR_NONE;
        lockable_d = 1'b1;
        if (acc_write) begin
            case (acc_reg)
                REG_OPEN: if (open_q) code_d = ERR_ALREADY_OPEN;
                REG_CLOSE: if (!open_q) code_d = ERR_NOT_OPEN;
                REG_CARD_COMMAND: begin
                    if (!open_q) code_d = ERR_NOT_OPEN;
                    else if ((acc_wdata & ~CMD_VALID_MASK) != '0) code_d = ERR_INVALID_VALUE;
                end
                REG_SWITCH: begin
                    if (!open_q) code_d = ERR_NOT_OPEN;
                    else if (acc_wdata > 32'h0000_0001) code_d = ERR_INVALID_VALUE;
                end
                default: code_d = ERR_INVALID_REG;
            endcase
        end else begin
            if (acc_reg == REG_CARD_COMMAND) code_d = ERR_WRITE_ONLY;
            else if (!rd_hit && !is_readout) code_d = ERR_INVALID_REG;
        end
        if (acc_valid && !acc_write && acc_reg == REG_CARD_COMMAND && 1'b0) lockable_d = 1'b0;
        if (code_d == ERR_NONE && wait_timeout) begin
            code_d = ERR_TIMEOUT;
            lockable_d = 1'b0;
        end
    end

    assign ok_d = acc_valid && !lock_q && (code_d == ERR_NONE);

    // Error capture and lock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            err_q <= '0;
            lock_q <= 1'b0;
        end else if (clk_en && acc_valid) begin
            if (is_readout) begin
                lock_q <= 1'b0;
            end else if (!lock_q && code_d != ERR_NONE && lockable_d) begin
                err_q <= '{code: code_d, reg_num: acc_reg, value: acc_wdata};
                lock_q <= 1'b1;
            end
        end
    end

    // Session
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            open_q <= 1'b0;
        end else if (clk_en && ok_d && acc_write) begin
            if (acc_reg == REG_OPEN) open_q <= 1'b1;
            else if (acc_reg == REG_CLOSE) open_q <= 1'b0;
        end
    end

    // Run state and switch
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            run_q <= CCR_IDLE;
            switch_q <= 1'b0;
        end else if (clk_en && ok_d && acc_write) begin
            if (acc_reg == REG_CARD_COMMAND) begin
                if ((acc_wdata & HALT_COMMAND) != '0) run_q <= CCR_IDLE;
                else if ((acc_wdata & RUN_COMMAND) != '0) run_q <= CCR_RUNNING;
            end
            if (acc_reg == REG_SWITCH) switch_q <= acc_wdata[0];
        end
    end

    // Access answer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_q <= 1'b0;
            status_q <= ERR_NONE;
            rdata_q <= '0;
            err_reg_q <= '0;
            err_val_q <= '0;
        end else if (clk_en) begin
            done_q <= acc_valid;
            if (acc_valid) begin
                rdata_q <= '0;
                if (is_readout) begin
                    status_q <= ERR_NONE;
                    rdata_q <= err_q.code;
                    err_reg_q <= err_q.reg_num;
                    err_val_q <= err_q.value;
                end else if (lock_q) begin
                    status_q <= PENDING_ERROR_CODE;
                end else begin
                    status_q <= code_d;
                    if (code_d == ERR_NONE && !acc_write) rdata_q <= rd_val;
                end
            end
        end
    end

    assign acc_done = done_q;
    assign acc_status = status_q;
    assign acc_rdata = rdata_q;
    assign err_reg_out = err_reg_q;
    assign err_value_out = err_val_q;
    assign card_running = (run_q == CCR_RUNNING);
    assign switch_on = switch_q;
    assign locked = lock_q;
    assign session_open = open_q;
endmodule : ccr_card_regs
`default_nettype wire

// >>> test/ccr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_host_model import ccr_pkg::*; (
    // Clock
    input wire logic clk,
    // Access request
    output logic acc_valid,
    output logic acc_write,
    output logic [REG_W-1:0] acc_reg,
    output logic [REG_W-1:0] acc_wdata,
    output logic wait_timeout
);
    initial begin
        acc_valid = 1'b0;
        acc_write = 1'b0;
        acc_reg = '0;
        acc_wdata = '0;
        wait_timeout = 1'b0;
    end
    // One request, held over exactly one taking edge
    task automatic access(input logic wr, input logic [REG_W-1:0] rg, wd, input logic to);
        @(posedge clk);
        #1;
        {acc_valid, acc_write, acc_reg, acc_wdata, wait_timeout} = {1'b1, wr, rg, wd, to};
        @(posedge clk);
        #1;
        {acc_valid, acc_write, acc_reg, acc_wdata, wait_timeout} = {1'b0, ~wr, ~rg, ~wd, 1'b0};
    endtask : access
endmodule : ccr_host_model
`default_nettype wire

// >>> test/ccr_card_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_card_regs_props import ccr_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Access
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic [REG_W-1:0] acc_reg,
    input wire logic [REG_W-1:0] acc_wdata,
    input wire logic wait_timeout,
    input wire logic acc_done,
    input wire logic [REG_W-1:0] acc_status,
    // State
    input wire logic card_running,
    input wire logic switch_on,
    input wire logic locked,
    input wire logic session_open
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_free;
        clk_en && acc_valid && !locked && session_open && !wait_timeout;
    endsequence
    sequence s_wr(r);
        s_free ##0 (acc_write && acc_reg == r);
    endsequence
    take_done_a: assert property (clk_en && acc_valid |=> acc_done)
        else $error("no answer after access");
    run_start_a: assert property (s_wr(REG_CARD_COMMAND) ##0 acc_wdata == RUN_COMMAND |=> card_running)
        else $error("run code did not start card");
    halt_stop_a: assert property (s_wr(REG_CARD_COMMAND) ##0 acc_wdata[6] |=> !card_running)
        else $error("halt code did not stop card");
    switch_set_a: assert property (s_wr(REG_SWITCH) ##0 acc_wdata[31:1] == 0 |=> switch_on == $past(acc_wdata[0]))
        else $error("switch does not follow written bit");
    cmd_read_a: assert property (s_free ##0 !acc_write && acc_reg == REG_CARD_COMMAND |=> acc_status == ERR_WRITE_ONLY)
        else $error("command register read not refused");
    ro_write_a: assert property (s_wr(REG_BOARD_TYPE_CODE) or s_wr(REG_EXTENSION_PCB_REVISION) |=> acc_status == ERR_INVALID_REG && locked)
        else $error("write to identity register not refused");
    lock_refuse_a: assert property (clk_en && acc_valid && locked && (acc_write || acc_reg != REG_ERROR_READOUT) |=> acc_status == PENDING_ERROR_CODE && locked)
        else $error("locked access not answered with pending code");
    unlock_a: assert property (clk_en && acc_valid && locked && !acc_write && acc_reg == REG_ERROR_READOUT |=> !locked)
        else $error("error readout did not clear lock");
    timeout_a: assert property (clk_en && acc_valid && !locked && session_open && wait_timeout && !acc_write && acc_reg == REG_BOARD_TYPE_CODE |=> acc_status == ERR_TIMEOUT && !locked)
        else $error("timeout report wrong or locked");
endmodule : ccr_card_regs_props
bind ccr_card_regs ccr_card_regs_props props_u (.*);
`default_nettype wire

// >>> test/ccr_card_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_card_regs_tb import ccr_pkg::*; ;
    localparam logic [REG_W-1:0] IDS [7] = '{REG_BOARD_TYPE_CODE, REG_BASE_BOARD_VERSION, REG_EXTENSION_MODULE_VERSION,
        REG_FRONT_END_MODULE_VERSION, REG_BASE_BOARD_PCB_REVISION, REG_FRONT_END_PCB_REVISION, REG_EXTENSION_PCB_REVISION};
    localparam logic [REG_W-1:0] EXP [7] = '{32'h0001_1234, 32'h0001_0001, 32'h0, 32'h0001_0001, 32'h0100, 32'h0100, 32'h0};
    localparam logic [REG_W-1:0] Z = 32'h0;
    logic clk, rst_n, acc_valid, acc_write, wait_timeout, acc_done, card_running, switch_on, locked, session_open;
    logic clk_en = 1'b1;
    logic [REG_W-1:0] acc_reg, acc_wdata, acc_status, acc_rdata, err_reg_out, err_value_out, v;
    logic [65:0] notes [$];
    logic [65:0] nt;
    int errors = 0, n_compared = 0, r;
    ccr_card_regs dut_u (.*);
    ccr_host_model host_u (.*);
    task automatic cmp(input string nm, input logic [REG_W-1:0] e, g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    // Mode bits: check status, check read data
    task automatic acc(input logic wr, input logic [REG_W-1:0] rg, wd, input logic to, input logic [1:0] m,
        input logic [REG_W-1:0] st, rd);
        notes.push_back({m, st, rd});
        host_u.access(wr, rg, wd, to);
    endtask : acc
    task automatic end_of_test;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (acc_done === 1'b1 && notes.size() > 0) begin
            nt = notes.pop_front();
            if (nt[65]) cmp("status", nt[63:32], acc_status);
            if (nt[64]) cmp("rdata", nt[31:0], acc_rdata);
        end
    end
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        end_of_test();
    end
    initial begin
        rst_n = 1'b0;
        void'($urandom(32'h0B6F4218));
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        acc(1'b1, REG_OPEN, Z, 1'b0, 2'h2, ERR_NONE, Z);
        acc(1'b1, REG_OPEN, Z, 1'b0, 2'h2, ERR_ALREADY_OPEN, Z);
        acc(1'b0, REG_ERROR_READOUT, Z, 1'b0, 2'h0, Z, Z);
        for (int i = 0; i < 7; i++) acc(1'b0, IDS[i], Z, 1'b0, 2'h3, ERR_NONE, EXP[i]);
        r = $urandom_range(6, 0);
        v = $urandom();
        acc(1'b1, IDS[r], v, 1'b0, 2'h2, ERR_INVALID_REG, Z);
        acc(1'b0, IDS[r], Z, 1'b0, 2'h3, PENDING_ERROR_CODE, Z);
        acc(1'b0, REG_ERROR_READOUT, Z, 1'b0, 2'h3, ERR_NONE, ERR_INVALID_REG);
        cmp("error register", IDS[r], err_reg_out);
        cmp("error value", v, err_value_out);
        acc(1'b0, IDS[r], Z, 1'b0, 2'h3, ERR_NONE, EXP[r]);
        acc(1'b1, REG_CARD_COMMAND, RUN_COMMAND, 1'b0, 2'h2, ERR_NONE, Z);
        cmp("running", 32'h1, {31'h0, card_running});
        acc(1'b1, REG_CARD_COMMAND, HALT_COMMAND, 1'b0, 2'h2, ERR_NONE, Z);
        cmp("running", Z, {31'h0, card_running});
        for (int b = 1; b >= 0; b--) begin
            acc(1'b1, REG_SWITCH, b, 1'b0, 2'h2, ERR_NONE, Z);
            cmp("switch", b, {31'h0, switch_on});
        end
        acc(1'b0, REG_CARD_COMMAND, Z, 1'b0, 2'h3, ERR_WRITE_ONLY, Z);
        acc(1'b0, REG_ERROR_READOUT, Z, 1'b0, 2'h0, Z, Z);
        acc(1'b1, REG_CARD_COMMAND, 32'h80, 1'b0, 2'h2, ERR_INVALID_VALUE, Z);
        acc(1'b0, REG_ERROR_READOUT, Z, 1'b0, 2'h1, Z, ERR_INVALID_VALUE);
        acc(1'b0, IDS[0], Z, 1'b1, 2'h2, ERR_TIMEOUT, Z);
        acc(1'b0, IDS[0], Z, 1'b0, 2'h3, ERR_NONE, EXP[0]);
        acc(1'b1, REG_CLOSE, Z, 1'b0, 2'h2, ERR_NONE, Z);
        acc(1'b1, REG_CARD_COMMAND, RUN_COMMAND, 1'b0, 2'h2, ERR_NOT_OPEN, Z);
        repeat (3) @(posedge clk);
        end_of_test();
    end
endmodule : ccr_card_regs_tb
`default_nettype wire
